/* src/usb_hub_pkg.sv */
// constants, register map and carrier types of the hub port control block
//
// Overview of operation
// - one upstream port, four downstream ports, each with power, indicator and overcurrent.
// - repeat line states downstream from upstream, and upstream from one downstream port.
// - full-speed and low-speed ports; idle polarity follows the detected port speed.
// - reference clock multiplied to internal clock; repeater waits for lock after reset.
// - power mode input high means bus-powered, low means self-powered.
// - each power enable pin is open-drain: driven low or released.
// - overcurrent at a port removes power from that port only.
// - overcurrent status of each port is reported to the host.
// - connect indicator is driven low while its port is enabled.
// - indicator inactive after reset and on any port disable.
// - power asserted only by a set-power request; removed at reset and overcurrent.
// - overcurrent sets the port overcurrent bit and its change bit.
// - upstream traffic goes only to currently enabled downstream ports.
`default_nettype none

package usb_hub_pkg;

    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int NUM_PORTS        = 4;
    localparam int CLK_FREQ_KHZ     = 10000;
    localparam int REF_CLK_KHZ      = 6000;
    localparam int INT_CLK_KHZ      = 48000;
    localparam int PLL_MULT         = INT_CLK_KHZ / REF_CLK_KHZ;
    localparam int PLL_LOCK_US      = 100;
    localparam int PLL_LOCK_CYCLES  = (PLL_LOCK_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int IDLE_HOLD_CYCLES = 2;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [4:0] REG_POWER_SET  = 5'h00;
    localparam logic [4:0] REG_POWER_CLR  = 5'h04;
    localparam logic [4:0] REG_ENABLE     = 5'h08;
    localparam logic [4:0] REG_STATUS     = 5'h0c;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h10;
    localparam logic [4:0] REG_IRQ_MASK   = 5'h14;

    localparam int STAT_OC_LSB   = 0;
    localparam int STAT_LS_LSB   = 4;
    localparam int STAT_BUS_BIT  = 8;
    localparam int STAT_LOCK_BIT = 9;
    localparam int STAT_RB_LSB   = 10;
    localparam int IRQ_OC_LSB    = 0;
    localparam int IRQ_OFF_LSB   = 4;

    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // ************************************************************
    // carriers between the top and each port controller
    // ************************************************************
    typedef struct packed {
        logic power_set;
        logic power_clr;
        logic enable_wr;
        logic enable_val;
    } port_ctl_s;

    typedef struct packed {
        logic powered;
        logic enabled;
        logic overcurrent;
        logic oc_event;
        logic off_event;
    } port_stat_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DOWN,
        ST_UP
    } rep_state_e;

endpackage : usb_hub_pkg

`default_nettype wire

/* src/port_power_ctrl.sv */
// power switch, enable and connect indicator of one downstream port
`default_nettype none

module port_power_ctrl
    import usb_hub_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire port_ctl_s  i_ctl,
    input  wire logic       i_overcurrent_sense,
    output port_stat_s      o_stat,
    output logic            o_power_line_oe,
    output logic            o_connect_indicator_n
);

    logic powered;
    logic enabled;
    logic oc_q;
    logic next_powered;
    logic next_enabled;
    logic hold_power;
    logic hold_enable;

    // ************************************************************
    // next state
    // ************************************************************
    // overcurrent overrides any request in the same cycle
    assign hold_power   = i_ctl.power_set | (powered & ~i_ctl.power_clr);
    assign next_powered = hold_power & ~i_overcurrent_sense;
    assign hold_enable  = i_ctl.enable_wr ? i_ctl.enable_val : enabled;
    assign next_enabled = hold_enable & next_powered;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            powered               <= 1'b0;
            enabled               <= 1'b0;
            oc_q                  <= 1'b0;
            o_power_line_oe       <= 1'b0;
            o_connect_indicator_n <= 1'b1;
        end else begin
            powered               <= next_powered;
            enabled               <= next_enabled;
            oc_q                  <= i_overcurrent_sense;
            o_power_line_oe       <= next_powered;
            o_connect_indicator_n <= ~next_enabled;
        end
    end

    assign o_stat.powered     = powered;
    assign o_stat.enabled     = enabled;
    assign o_stat.overcurrent = oc_q;
    assign o_stat.oc_event    = i_overcurrent_sense & ~oc_q;
    assign o_stat.off_event   = enabled & ~next_enabled;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_oc_removes_power: assert property (
        i_overcurrent_sense |=> (!o_power_line_oe && o_connect_indicator_n))
        else $error("power stayed on during overcurrent");

    a_power_by_request: assert property (
        $rose(o_power_line_oe) |-> $past(i_ctl.power_set))
        else $error("power came on without a set request");

    a_indicator_enable: assert property (
        enabled |-> !o_connect_indicator_n)
        else $error("indicator inactive while port enabled");

    a_disable_clears: assert property (
        $fell(enabled) |-> o_connect_indicator_n && !$past(o_connect_indicator_n))
        else $error("indicator not cleared on disable");

endmodule : port_power_ctrl

`default_nettype wire

/* src/usb_hub_port_control.sv */
// top of the hub port control: bus slave, repeater and four port controllers
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none

module usb_hub_port_control
    import usb_hub_pkg::*;
#(
    parameter int PORTS       = NUM_PORTS,
    parameter int LOCK_CYCLES = PLL_LOCK_CYCLES,
    parameter int IDLE_HOLD   = IDLE_HOLD_CYCLES
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_bus_powered,
    // avalon-mm slave
    input  wire logic [4:0]       i_avs_address,
    input  wire logic             i_avs_read,
    input  wire logic             i_avs_write,
    input  wire logic [31:0]      i_avs_writedata,
    input  wire logic [3:0]       i_avs_byteenable,
    output logic      [31:0]      o_avs_readdata,
    output logic                  o_avs_waitrequest,
    output logic                  o_irq,
    // per port power and status
    input  wire logic [PORTS-1:0] i_overcurrent_sense,
    input  wire logic [PORTS-1:0] i_port_power_enable_line,
    output logic      [PORTS-1:0] o_port_power_enable_line,
    output logic      [PORTS-1:0] o_port_power_enable_line_oe,
    output logic      [PORTS-1:0] o_port_connect_indicator_n,
    // upstream line pair
    input  wire logic             i_upstream_line_plus,
    output logic                  o_upstream_line_plus,
    output logic                  o_upstream_line_plus_oe,
    input  wire logic             i_upstream_line_minus,
    output logic                  o_upstream_line_minus,
    output logic                  o_upstream_line_minus_oe,
    // downstream line pairs
    input  wire logic [PORTS-1:0] i_downstream_line_plus,
    output logic      [PORTS-1:0] o_downstream_line_plus,
    output logic      [PORTS-1:0] o_downstream_line_plus_oe,
    input  wire logic [PORTS-1:0] i_downstream_line_minus,
    output logic      [PORTS-1:0] o_downstream_line_minus,
    output logic      [PORTS-1:0] o_downstream_line_minus_oe
);

    // idle (j) state; low-speed ports idle with minus high
    function automatic logic line_idle(input logic plus, input logic minus, input logic low);
        line_idle = low ? (!plus && minus) : (plus && !minus);
    endfunction : line_idle

    // ************************************************************
    // declarations
    // ************************************************************
    port_ctl_s  port_ctl  [PORTS];
    port_stat_s port_stat [PORTS];

    logic [PORTS-1:0] enabled;
    logic [PORTS-1:0] overcurrent;
    logic [PORTS-1:0] oc_event;
    logic [PORTS-1:0] off_event;
    logic [PORTS-1:0] power_oe;
    logic [PORTS-1:0] indicator_n;
    logic [PORTS-1:0] low_speed;
    logic [PORTS-1:0] down_active;
    logic [7:0]       irq_status;
    logic [7:0]       irq_mask;
    logic [7:0]       irq_events;
    logic [7:0]       next_irq_status;
    logic [31:0]      rd_mux;
    logic [31:0]      rd_status;
    logic             rd_take;
    logic             wr_fire;
    logic             wr_lane0;
    logic [7:0]       wr_byte;
    logic             locked;
    logic [15:0]      lock_cnt;
    logic             bus_powered;

    rep_state_e       state;
    rep_state_e       next_state;
    logic [1:0]       up_src;
    logic [1:0]       next_up_src;
    logic [7:0]       idle_cnt;
    logic             up_idle;
    logic             src_idle;
    logic             src_live;
    logic             any_down;
    logic [1:0]       first_down;

    // ************************************************************
    // avalon-mm slave
    // ************************************************************
    // one wait cycle on every access, so read data always comes from a flop
    assign rd_take  = i_avs_read && o_avs_waitrequest;
    assign wr_fire  = i_avs_write && !o_avs_waitrequest;
    assign wr_lane0 = wr_fire && i_avs_byteenable[0];
    assign wr_byte  = i_avs_writedata[7:0];

    assign rd_status = 32'({i_port_power_enable_line, locked, bus_powered, low_speed,
                            overcurrent});

    always_comb begin
        unique case (i_avs_address)
            REG_POWER_SET,
            REG_POWER_CLR:  rd_mux = 32'(power_oe);
            REG_ENABLE:     rd_mux = 32'(enabled);
            REG_STATUS:     rd_mux = rd_status;
            REG_IRQ_STATUS: rd_mux = 32'(irq_status);
            REG_IRQ_MASK:   rd_mux = 32'(irq_mask);
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
            if (rd_take) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    assign irq_events = {off_event, oc_event};
    // a new event wins over a clear written in the same cycle
    assign next_irq_status = (irq_status & ~((wr_lane0 && i_avs_address == REG_IRQ_STATUS)
                             ? wr_byte : 8'h00)) | irq_events;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status <= 8'h00;
            irq_mask   <= IRQ_MASK_RESET;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_lane0 && i_avs_address == REG_IRQ_MASK) begin
                irq_mask <= wr_byte;
            end
            o_irq <= |(next_irq_status & irq_mask);
        end
    end

    // ************************************************************
    // reference clock lock and power mode
    // ************************************************************
    // the analog multiplier lives outside; this only holds the repeater off until lock
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_cnt    <= 16'h0000;
            locked      <= 1'b0;
            bus_powered <= 1'b0;
        end else begin
            bus_powered <= i_bus_powered;
            if (!locked) begin
                lock_cnt <= lock_cnt + 16'h0001;
                locked   <= (lock_cnt == 16'(LOCK_CYCLES - 1));
            end
        end
    end

    // ************************************************************
    // port controllers
    // ************************************************************
    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_port
            // each port owns its own controller, so events never cross ports
            assign port_ctl[p].power_set  = wr_lane0 && i_avs_address == REG_POWER_SET
                                            && wr_byte[p];
            assign port_ctl[p].power_clr  = wr_lane0 && i_avs_address == REG_POWER_CLR
                                            && wr_byte[p];
            assign port_ctl[p].enable_wr  = wr_lane0 && i_avs_address == REG_ENABLE;
            assign port_ctl[p].enable_val = wr_byte[p];

            port_power_ctrl u_port (
                .i_clk                 (i_clk),
                .i_resetn              (i_resetn),
                .i_ctl                 (port_ctl[p]),
                .i_overcurrent_sense   (i_overcurrent_sense[p]),
                .o_stat                (port_stat[p]),
                .o_power_line_oe       (power_oe[p]),
                .o_connect_indicator_n (indicator_n[p])
            );

            assign enabled[p]     = port_stat[p].enabled;
            assign overcurrent[p] = port_stat[p].overcurrent;
            assign oc_event[p]    = port_stat[p].oc_event;
            assign off_event[p]   = port_stat[p].off_event;
            assign down_active[p] = enabled[p] && !line_idle(i_downstream_line_plus[p],
                                    i_downstream_line_minus[p], low_speed[p]);

            // speed is sampled from the idle lines when the port becomes enabled
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    low_speed[p] <= 1'b0;
                end else if (port_ctl[p].enable_wr && port_ctl[p].enable_val && !enabled[p]) begin
                    low_speed[p] <= i_downstream_line_minus[p] && !i_downstream_line_plus[p];
                end
            end
        end
    endgenerate

    // open-drain: the pin is only ever pulled low, the off level comes from the pull-up
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_power_enable_line    <= '0;
            o_port_power_enable_line_oe <= '0;
            o_port_connect_indicator_n  <= '1;
        end else begin
            o_port_power_enable_line    <= '0;
            o_port_power_enable_line_oe <= power_oe;
            o_port_connect_indicator_n  <= indicator_n;
        end
    end

    // ************************************************************
    // repeater
    // ************************************************************
    assign up_idle  = line_idle(i_upstream_line_plus, i_upstream_line_minus, 1'b0);
    assign any_down = |down_active;

    always_comb begin
        first_down = 2'd0;
        for (int k = PORTS - 1; k >= 0; k--) begin
            if (down_active[k]) begin
                first_down = 2'(k);
            end
        end
    end

    assign src_idle = (state == ST_UP) ? line_idle(i_downstream_line_plus[up_src],
                      i_downstream_line_minus[up_src], low_speed[up_src]) : up_idle;
    assign src_live = (state != ST_UP) || enabled[up_src];

    always_comb begin
        next_state  = state;
        next_up_src = up_src;
        unique case (state)
            ST_IDLE: begin
                if (locked && !up_idle) begin
                    next_state = ST_DOWN;
                end else if (locked && any_down) begin
                    next_state  = ST_UP;
                    next_up_src = first_down;
                end
            end
            ST_DOWN,
            ST_UP: begin
                if (!src_live || (src_idle && idle_cnt == 8'(IDLE_HOLD - 1))) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state    <= ST_IDLE;
            up_src   <= 2'd0;
            idle_cnt <= 8'h00;
        end else begin
            state    <= next_state;
            up_src   <= next_up_src;
            idle_cnt <= (src_idle && state != ST_IDLE) ? idle_cnt + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_upstream_line_plus       <= 1'b0;
            o_upstream_line_minus      <= 1'b0;
            o_upstream_line_plus_oe    <= 1'b0;
            o_upstream_line_minus_oe   <= 1'b0;
            o_downstream_line_plus     <= '0;
            o_downstream_line_minus    <= '0;
            o_downstream_line_plus_oe  <= '0;
            o_downstream_line_minus_oe <= '0;
        end else begin
            o_upstream_line_plus       <= i_downstream_line_plus[next_up_src];
            o_upstream_line_minus      <= i_downstream_line_minus[next_up_src];
            o_upstream_line_plus_oe    <= (next_state == ST_UP);
            o_upstream_line_minus_oe   <= (next_state == ST_UP);
            o_downstream_line_plus     <= {PORTS{i_upstream_line_plus}};
            o_downstream_line_minus    <= {PORTS{i_upstream_line_minus}};
            o_downstream_line_plus_oe  <= (next_state == ST_DOWN) ? enabled : '0;
            o_downstream_line_minus_oe <= (next_state == ST_DOWN) ? enabled : '0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_up_start;
        state == ST_IDLE && locked && up_idle && any_down;
    endsequence

    sequence s_up_drive;
        o_upstream_line_plus_oe && o_upstream_line_minus_oe;
    endsequence

    a_repeat_upward: assert property (
        s_up_start |=> s_up_drive)
        else $error("downstream activity not repeated upward");

    a_only_enabled: assert property (
        (o_downstream_line_plus_oe & ~$past(enabled)) == '0)
        else $error("traffic sent to a disabled port");

    a_lock_wait: assert property (
        !locked |-> state == ST_IDLE && !o_upstream_line_plus_oe)
        else $error("repeater active before lock");

    a_oc_change_bit: assert property (
        |oc_event |=> (irq_status[3:0] & $past(oc_event)) == $past(oc_event))
        else $error("overcurrent change bit not set");

    a_mode_status: assert property (
        $past(i_resetn) |-> bus_powered == $past(i_bus_powered))
        else $error("power mode not followed");

    a_wait_one: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1
        o_avs_waitrequest)
        else $error("waitrequest not one cycle");

    a_irq_level: assert property (
        o_irq == |(irq_status & $past(irq_mask)))
        else $error("interrupt low with unmasked status");

endmodule : usb_hub_port_control

`default_nettype wire

/* src/placeholder_unused.sv */
// intentionally empty design unit list
`default_nettype none
`default_nettype wire

/* bench/usb_host_model.sv */
// upstream host model that drives and releases the upstream line pair
`default_nettype none

module usb_host_model (
    input  wire logic i_clk,
    input  wire logic i_hub_plus,
    input  wire logic i_hub_plus_oe,
    input  wire logic i_hub_minus,
    input  wire logic i_hub_minus_oe,
    output logic      o_plus,
    output logic      o_minus
);
    timeunit 1ns;
    timeprecision 1ns;

    logic drive = 1'b0;
    logic dp    = 1'b1;
    logic dm    = 1'b0;

    // released pair settles to j: pull-up on plus, pull-down on minus
    assign o_plus  = i_hub_plus_oe ? i_hub_plus : (drive ? dp : 1'b1);
    assign o_minus = i_hub_minus_oe ? i_hub_minus : (drive ? dm : 1'b0);

    // k for n cycles, then se0 twice and j once as end of packet
    task automatic send_k(input int n);
        @(posedge i_clk);
        drive <= 1'b1;
        dp    <= 1'b0;
        dm    <= 1'b1;
        repeat (n) @(posedge i_clk);
        dm <= 1'b0;
        repeat (2) @(posedge i_clk);
        dp <= 1'b1;
        @(posedge i_clk);
        drive <= 1'b0;
    endtask : send_k
endmodule : usb_host_model

`default_nettype wire

/* bench/tb_usb_hub_port_control.sv */
// self-checking bench of the hub port control block
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_usb_hub_port_control import usb_hub_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, resetn, bus_powered, avs_read, avs_write, waitreq, irq;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  oc, dev_k, pw, pw_oe, ind_n, dn_p, dn_p_oe, dn_m, dn_m_oe;
    logic        up_p, up_p_oe, up_m, up_m_oe, host_p, host_m;
    int          errors = 0;
    int          checks = 0;

    // short lock wait keeps the run brief
    usb_hub_port_control #(.LOCK_CYCLES(4)) i_dut (
        .i_clk(clk), .i_resetn(resetn), .i_bus_powered(bus_powered),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
        .i_overcurrent_sense(oc), .i_port_power_enable_line((pw_oe & pw) | ~pw_oe),
        .o_port_power_enable_line(pw), .o_port_power_enable_line_oe(pw_oe),
        .o_port_connect_indicator_n(ind_n),
        .i_upstream_line_plus(host_p), .o_upstream_line_plus(up_p),
        .o_upstream_line_plus_oe(up_p_oe), .i_upstream_line_minus(host_m),
        .o_upstream_line_minus(up_m), .o_upstream_line_minus_oe(up_m_oe),
        .i_downstream_line_plus((dn_p_oe & dn_p) | (~dn_p_oe & ~dev_k)),
        .o_downstream_line_plus(dn_p), .o_downstream_line_plus_oe(dn_p_oe),
        .i_downstream_line_minus((dn_m_oe & dn_m) | (~dn_m_oe & dev_k)),
        .o_downstream_line_minus(dn_m), .o_downstream_line_minus_oe(dn_m_oe));

    usb_host_model i_host (.i_clk(clk), .i_hub_plus(up_p), .i_hub_plus_oe(up_p_oe),
        .i_hub_minus(up_m), .i_hub_minus_oe(up_m_oe), .o_plus(host_p), .o_minus(host_m));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************
    // tasks
    // ************
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (waitreq !== 1'b0) begin
            errors++;
            report_and_stop();
        end
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic t_reset;
        settle(0);
        `CHK({pw_oe, pw, ind_n, irq}, 13'h001e)
        bus(1'b0, REG_IRQ_MASK, 32'h0, q);
        `CHK(q, 32'h0)
        bus(1'b0, 5'h18, 32'h0, q);
        `CHK(q, 32'h0)
        $display("test reset done");
    endtask : t_reset

    task automatic t_power;
        bus(1'b1, REG_POWER_SET, 32'h7, q);
        settle(2);
        `CHK({pw_oe, pw}, 8'h70)
        bus(1'b1, REG_ENABLE, 32'h7, q);
        settle(2);
        `CHK(ind_n, 4'h8)
        $display("test power done");
    endtask : t_power

    task automatic t_overcurrent;
        bus(1'b1, REG_IRQ_MASK, 32'h4, q);
        @(posedge clk);
        oc <= 4'h4;
        settle(3);
        `CHK(pw_oe, 4'h3)
        `CHK(ind_n, 4'hc)
        `CHK(irq, 1'b1)
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK(q, 32'h3304)
        bus(1'b0, REG_IRQ_STATUS, 32'h0, q);
        `CHK(q, 32'h44)
        // a power request during overcurrent must be ignored
        bus(1'b1, REG_POWER_SET, 32'h4, q);
        settle(2);
        `CHK(pw_oe, 4'h3)
        bus(1'b1, REG_IRQ_STATUS, 32'h44, q);
        settle(2);
        `CHK(irq, 1'b0)
        @(posedge clk);
        oc <= 4'h0;
        bus_powered <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK(q[8], 1'b0)
        $display("test overcurrent done");
    endtask : t_overcurrent

    task automatic t_repeat;
        fork
            i_host.send_k(5);
            begin
                repeat (4) @(negedge clk);
                `CHK({dn_p_oe, dn_m_oe, dn_p[1:0], dn_m[1:0], up_p_oe, up_m_oe}, 14'h0ccc)
            end
        join
        settle(8);
        `CHK({dn_p_oe, dn_m_oe}, 8'h00)
        @(posedge clk);
        dev_k <= 4'h2;
        settle(3);
        `CHK({up_p_oe, up_m_oe, up_p, up_m}, 4'hd)
        @(posedge clk);
        dev_k <= 4'h0;
        settle(8);
        `CHK({up_p_oe, up_m_oe}, 2'b00)
        // removing power from port 0 must drop its indicator and leave port 1 alone
        bus(1'b1, REG_POWER_CLR, 32'h1, q);
        settle(2);
        `CHK({pw_oe, ind_n}, 8'h2d)
        $display("test repeat done");
    endtask : t_repeat

    initial begin
        resetn        = 1'b0;
        bus_powered   = 1'b1;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_address   = 5'h0;
        avs_writedata = 32'h0;
        oc            = 4'h0;
        dev_k         = 4'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_power();
        t_overcurrent();
        t_repeat();
        report_and_stop();
    end
endmodule : tb_usb_hub_port_control

`default_nettype wire
